/* File: rtl/readout_buffer_message_control.sv */
// Readout buffer message controller: message bus, status latch,
// slave-ready / finished handshake and an AHB-Lite register slave.
// Assumes all inputs are synchronous to hclk and accept strobes are
// one-cycle pulses from the trigger link receiver.
// Notes on behaviour
// - On first-level accept, send the input buffer number to the modules.
// - On second-level accept, send the buffer number to be read out.
// - Message bus is 12 bits: 4-bit type, 8-bit value.
// - First-level accept issues type 1 with input buffer number 0 to 63.
// - First-level accept issues type 3 with the low 8 crossing bits.
// - Second-level accept issues type 4 with scan buffer number 0 to 63.
// - Second-level accept issues type 5 with the event number.
// - Type 13 clears all error conditions on the status bus.
// - Type 14 value resets input FIFOs or reinitialises the whole module.
// - Status bits are active low and held in latches.
// - Slave-ready and finished are open-collector, active low lines.
// - After second-level accept and data ready, pull slave-ready low.
// - On finished low, release slave-ready to permit the next transfer.
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module readout_buffer_message_control #(
    parameter int QUEUE_W = 3
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic first_level_accept,
    input wire logic second_level_accept,
    input wire logic [23:0] crossing_number,
    output logic [11:0] message,
    output logic message_valid,
    input wire logic [9:0] status_n,
    input wire logic slave_ready_n_in,
    output logic slave_ready_n_out,
    output logic slave_ready_n_oe,
    input wire logic finished_n_in,
    output logic finished_n_out,
    output logic finished_n_oe
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {HS_IDLE, HS_WAIT_DATA, HS_READY, HS_RELEASE} hs_e;

    typedef struct packed {
        // Message bus output
        logic [11:0] msg;
        logic msg_v;

        // Buffer, crossing and event numbers carried by messages
        logic [5:0] in_buf;
        logic [5:0] scan_buf;
        logic [7:0] xing;
        logic [7:0] event_num;

        // Pending message pairs and transfers still owed a slave-ready
        logic [1:0] l1_pend;
        logic [1:0] l2_pend;
        logic [QUEUE_W:0] out_pend;

        // Latched status, handshake state and software control
        logic [9:0] stat;
        hs_e hs;
        logic enable;
        logic [2:0] cmd;
        logic [15:0] event_count;

        // Bus data phase and the first status stage
        logic ph_wr;
        logic ph_rd;
        logic [7:0] ph_addr;
        logic [31:0] rdata;
        logic [9:0] stat_sync;
    } state_s;

    state_s cur_reg;
    state_s cur_next;

    // ----------------------------------------------------------------
    // Status inputs
    // ----------------------------------------------------------------
    // Every line is active low; invert per bit so one means asserted
    logic [msg_ctrl_pkg::STAT_W-1:0] stat_asserted;

    genvar gi;
    generate
        for (gi = 0; gi < msg_ctrl_pkg::STAT_W; gi++) begin : g_stat
            assign stat_asserted[gi] = ~status_n[gi];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic addr_phase;
        logic [QUEUE_W:0] pend;
        logic [2:0] wr_cmd;
        addr_phase = 1'b0;
        pend = '0;
        wr_cmd = 3'h0;
        cur_next = cur_reg;
        cur_next.msg_v = 1'b0;

        // Two register stages before the handshake looks at the status
        cur_next.stat_sync = stat_asserted;
        cur_next.stat = cur_reg.stat_sync;

        // ------------------------------------------------------------
        // Bus slave
        // ------------------------------------------------------------
        // Always zero wait states, word registers only
        addr_phase = hsel && hready && htrans[1];
        if (cur_reg.ph_wr) begin
            if (cur_reg.ph_addr == msg_ctrl_pkg::A_CTRL) begin
                // Merged after the message issue so a new request is never lost
                wr_cmd = {hwdata[msg_ctrl_pkg::C_RST_FULL],
                          hwdata[msg_ctrl_pkg::C_RST_FIFO],
                          hwdata[msg_ctrl_pkg::C_CLEAR]};
                cur_next.enable = hwdata[msg_ctrl_pkg::C_ENABLE];
            end
        end
        cur_next.ph_wr = addr_phase && hwrite;
        cur_next.ph_rd = addr_phase && !hwrite;
        cur_next.ph_addr = haddr[7:0];
        if (addr_phase && !hwrite) begin
            case (haddr[7:0])
                msg_ctrl_pkg::A_CTRL: begin
                    cur_next.rdata = {28'h0000000, cur_reg.enable, 3'h0};
                end
                msg_ctrl_pkg::A_STATUS: begin
                    cur_next.rdata = {20'h00000,
                                      cur_reg.hs == HS_READY,
                                      cur_reg.hs == HS_WAIT_DATA,
                                      cur_reg.stat};
                end
                msg_ctrl_pkg::A_COUNT: begin
                    cur_next.rdata = {16'h0000, cur_reg.event_count};
                end
                msg_ctrl_pkg::A_EVENT: begin
                    cur_next.rdata = {12'h000,
                                      cur_reg.scan_buf,
                                      cur_reg.in_buf,
                                      cur_reg.xing};
                end
                default: begin
                    cur_next.rdata = 32'h0000_0000;
                end
            endcase
        end

        // ------------------------------------------------------------
        // Accept capture and message issue
        // ------------------------------------------------------------
        // Accept strobes queue their message pairs; second of pair follows
        if (first_level_accept && cur_reg.enable) begin
            cur_next.l1_pend = 2'h2;
            cur_next.xing = crossing_number[7:0];
        end
        if (second_level_accept && cur_reg.enable) begin
            cur_next.l2_pend = 2'h2;
        end

        // One message per cycle; first-level pair has priority
        if (cur_reg.l1_pend == 2'h2) begin
            cur_next.msg = {msg_ctrl_pkg::MT_IN_BUF, 2'b00, cur_reg.in_buf};
            cur_next.msg_v = 1'b1;
            cur_next.l1_pend = 2'h1;
        end else if (cur_reg.l1_pend == 2'h1) begin
            cur_next.msg = {msg_ctrl_pkg::MT_XING, cur_reg.xing};
            cur_next.msg_v = 1'b1;
            cur_next.l1_pend = 2'h0;
            cur_next.in_buf = cur_reg.in_buf + 6'h01;
        end else if (cur_reg.l2_pend == 2'h2) begin
            cur_next.msg = {msg_ctrl_pkg::MT_SCAN_BUF, 2'b00, cur_reg.scan_buf};
            cur_next.msg_v = 1'b1;
            cur_next.l2_pend = 2'h1;
        end else if (cur_reg.l2_pend == 2'h1) begin
            cur_next.msg = {msg_ctrl_pkg::MT_EVENT, cur_reg.event_num};
            cur_next.msg_v = 1'b1;
            cur_next.l2_pend = 2'h0;
            cur_next.scan_buf = cur_reg.scan_buf + 6'h01;
            cur_next.event_num = cur_reg.event_num + 8'h01;
            pend = cur_next.out_pend + 1'b1;
            cur_next.out_pend = pend;
        end else if (cur_reg.cmd[0]) begin
            cur_next.msg = {msg_ctrl_pkg::MT_CLEAR, 8'h00};
            cur_next.msg_v = 1'b1;
            cur_next.cmd[0] = 1'b0;
        end else if (cur_reg.cmd[1]) begin
            cur_next.msg = {msg_ctrl_pkg::MT_RESET, msg_ctrl_pkg::RST_VAL_FIFO};
            cur_next.msg_v = 1'b1;
            cur_next.cmd[1] = 1'b0;
        end else if (cur_reg.cmd[2]) begin
            cur_next.msg = {msg_ctrl_pkg::MT_RESET, msg_ctrl_pkg::RST_VAL_FULL};
            cur_next.msg_v = 1'b1;
            cur_next.cmd[2] = 1'b0;
        end
        // Only the codes above ever reach the bus; idle shows type 0
        if (!cur_next.msg_v) begin
            cur_next.msg = {msg_ctrl_pkg::MT_IDLE, 8'h00};
        end
        // A write landing as its command goes out must not be cleared
        cur_next.cmd = cur_next.cmd | wr_cmd;

        // ------------------------------------------------------------
        // Slave-ready handshake
        // ------------------------------------------------------------
        // One event at a time; out_pend wraps to zero past 15 pending transfers, dropping all of them
        case (cur_reg.hs)
            HS_IDLE: begin
                if (cur_reg.out_pend != '0) begin
                    cur_next.hs = HS_WAIT_DATA;
                end
            end
            HS_WAIT_DATA: begin
                // Wait for the modules to finish filling the buffers
                if (!cur_reg.stat[msg_ctrl_pkg::ST_IN_BUSY]) begin
                    cur_next.hs = HS_READY;
                end
            end
            HS_READY: begin
                if (!finished_n_in) begin
                    cur_next.hs = HS_RELEASE;
                    cur_next.event_count = cur_reg.event_count + 16'h0001;
                    pend = cur_next.out_pend - 1'b1;
                    cur_next.out_pend = pend;
                end
            end
            HS_RELEASE: begin
                // Finished must return high before another slave-ready
                if (finished_n_in) begin
                    cur_next.hs = HS_IDLE;
                end
            end
            default: cur_next.hs = HS_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_reg <= '0;
            cur_reg.hs <= HS_IDLE;
            cur_reg.enable <= msg_ctrl_pkg::CTRL_RESET[msg_ctrl_pkg::C_ENABLE];
        end else begin
            cur_reg <= cur_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign message = cur_reg.msg;
    assign message_valid = cur_reg.msg_v;
    assign hrdata = cur_reg.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    // Open collector: only ever pull low, enable is active low
    assign slave_ready_n_out = 1'b0;
    assign slave_ready_n_oe = (cur_reg.hs != HS_READY);
    assign finished_n_out = 1'b0;
    assign finished_n_oe = 1'b1;
endmodule

`default_nettype wire

/* File: pkg/msg_ctrl_pkg.sv */
// Constants for the readout buffer message controller.
// Assumes one 10 MHz clock domain; no other package is needed.
package msg_ctrl_pkg;
    // ----------------------------------------------------------------
    // Message bus layout
    // ----------------------------------------------------------------
    localparam int MSG_W = 12;
    localparam int TYPE_W = 4;
    localparam int VAL_W = 8;
    localparam int STAT_W = 10;
    localparam int BUF_W = 6;
    localparam int XING_W = 24;
    // ----------------------------------------------------------------
    // Message type codes
    // ----------------------------------------------------------------
    localparam logic [3:0] MT_IDLE = 4'h0;
    localparam logic [3:0] MT_IN_BUF = 4'h1;
    localparam logic [3:0] MT_XING = 4'h3;
    localparam logic [3:0] MT_SCAN_BUF = 4'h4;
    localparam logic [3:0] MT_EVENT = 4'h5;
    localparam logic [3:0] MT_CLEAR = 4'hd;
    localparam logic [3:0] MT_RESET = 4'he;
    // Values carried by the reset message
    localparam logic [7:0] RST_VAL_FIFO = 8'h01;
    localparam logic [7:0] RST_VAL_FULL = 8'h02;
    // ----------------------------------------------------------------
    // Status bus bit positions (bus is active low)
    // ----------------------------------------------------------------
    localparam int ST_IN_BUSY = 0;
    localparam int ST_SCAN_BUSY = 1;
    // ----------------------------------------------------------------
    // Register map, byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_COUNT = 8'h08;
    localparam logic [7:0] A_EVENT = 8'h0c;
    // Control register bit positions (bits 0 to 2 write one, self clearing; bit 3 holds enable)
    localparam int C_CLEAR = 0;
    localparam int C_RST_FIFO = 1;
    localparam int C_RST_FULL = 2;
    localparam int C_ENABLE = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0008;
endpackage

/* File: test/rbmc_asserts.sv */
// Concurrent checks on the ports of the message controller.
// Assumes it is bound into the design's top module, one clock domain.
`timescale 1ns/1ns
`default_nettype none
module rbmc_check (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic first_level_accept,
    input wire logic second_level_accept,
    input wire logic [23:0] crossing_number,
    input wire logic [11:0] message,
    input wire logic message_valid,
    input wire logic slave_ready_n_out,
    input wire logic slave_ready_n_oe,
    input wire logic finished_n_in,
    input wire logic finished_n_oe
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_type_legal: assert property (
        message_valid |-> message[11:8] inside {4'h1, 4'h3, 4'h4, 4'h5, 4'hd, 4'he})
        else $error("unused message type on bus");
    a_first_pair: assert property (
        first_level_accept ##1 !first_level_accept |=> message_valid && message[11:8] == 4'h1
        ##1 message[11:8] == 4'h3 && message[7:0] == $past(crossing_number[7:0], 3))
        else $error("first level message pair wrong");
    a_second_pair: assert property (
        second_level_accept && !first_level_accept && !message_valid ##1 !first_level_accept
        |=> message[11:8] == 4'h4 ##1 message[11:8] == 4'h5)
        else $error("second level message pair wrong");
    a_buf_range: assert property (
        message_valid && message[11:8] inside {4'h1, 4'h4} |-> message[7:6] == 2'h0)
        else $error("buffer number above 63");
    a_sr_release: assert property (
        !finished_n_in && !slave_ready_n_oe |=> slave_ready_n_oe)
        else $error("slave ready held after finished");
    a_sr_rearm: assert property (
        $fell(slave_ready_n_oe) |-> $past(finished_n_in))
        else $error("slave ready asserted while finished low");
    a_sr_drive: assert property (!slave_ready_n_oe |-> !slave_ready_n_out)
        else $error("slave ready driven high");
    a_fin_free: assert property (finished_n_oe)
        else $error("finished line driven");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus response not okay");
    cover property (first_level_accept);
    cover property (!finished_n_in && !slave_ready_n_oe);
    cover property (message_valid && message[11:8] == 4'he);
endmodule

bind readout_buffer_message_control rbmc_check u_rbmc_check (.hclk(hclk), .hresetn(hresetn),
    .hreadyout(hreadyout), .hresp(hresp), .first_level_accept(first_level_accept),
    .second_level_accept(second_level_accept), .crossing_number(crossing_number),
    .message(message), .message_valid(message_valid), .slave_ready_n_out(slave_ready_n_out),
    .slave_ready_n_oe(slave_ready_n_oe), .finished_n_in(finished_n_in),
    .finished_n_oe(finished_n_oe));
`default_nettype wire

/* File: test/buffer_far_side.sv */
// Behavioural buffer modules and buffer driver on the far side.
// Assumes open-collector lines resolved by the bench, pull-up idle.
`timescale 1ns/1ns
`default_nettype none
module buffer_far_side (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [11:0] message,
    input wire logic message_valid,
    input wire logic sync_err,
    input wire logic [3:0] fin_delay,
    input wire logic slave_ready_line,
    output logic [9:0] status_n,
    output logic finished_n
);
    logic [3:0] busy_cnt;
    logic [3:0] wait_cnt;
    logic ctrl_err;
    logic held_err;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            held_err <= 1'b0;
            busy_cnt <= 4'h0;
            wait_cnt <= 4'h0;
            ctrl_err <= 1'b0;
            finished_n <= 1'b1;
        end else begin
            if (message_valid && message[11:8] == 4'h1)
                busy_cnt <= 4'h6;
            else if (busy_cnt != 4'h0)
                busy_cnt <= busy_cnt - 4'h1;
            if (message_valid && !(message[11:8] inside {4'h1, 4'h3, 4'h4, 4'h5, 4'hd, 4'he}))
                ctrl_err <= 1'b1;
            else if (message_valid && message[11:8] == 4'hd)
                ctrl_err <= 1'b0;
            // A lost link corrupts words; the flag holds until a type 1 or type 13
            if (sync_err)
                held_err <= 1'b1;
            else if (message_valid && message[11:8] inside {4'h1, 4'hd})
                held_err <= 1'b0;
            // Finished is let go once slave ready is, so the line floats back up
            if (slave_ready_line) begin
                wait_cnt <= 4'h0;
                finished_n <= 1'b1;
            end else if (wait_cnt == fin_delay)
                finished_n <= 1'b0;
            else
                wait_cnt <= wait_cnt + 4'h1;
        end
    end
    // Active low; reserved bits idle high
    assign status_n = {3'b111, !ctrl_err, 2'b11, !held_err, !sync_err, slave_ready_line,
        busy_cnt == 4'h0};
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench: AHB-Lite master tasks, accept strobes, message log.
// Assumes the package and design are compiled first.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, fla, sla, message_valid;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [23:0] xing;
    logic [11:0] message;
    logic [9:0] status_n;
    logic sr_out, sr_oe, fin_out, fin_oe, fin_n, sr_line, fin_line, sync_err;
    logic [3:0] fin_delay;
    logic [11:0] mq[$];
    logic [31:0] cw[3] = '{32'h9, 32'ha, 32'hc};
    logic [11:0] ce[3] = '{12'hd00, 12'he01, 12'he02};
    logic [11:0] cm[3] = '{12'hf00, 12'hfff, 12'hfff};
    int err_total = 0;
    int num_checks = 0;
    int k;
    assign sr_line = sr_oe | sr_out;
    assign fin_line = fin_n & (fin_oe | fin_out);
    readout_buffer_message_control u_readout_buffer_message_control (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .first_level_accept(fla),
        .second_level_accept(sla), .crossing_number(xing), .message(message),
        .message_valid(message_valid), .status_n(status_n), .slave_ready_n_in(sr_line),
        .slave_ready_n_out(sr_out), .slave_ready_n_oe(sr_oe), .finished_n_in(fin_line),
        .finished_n_out(fin_out), .finished_n_oe(fin_oe));
    buffer_far_side u_buffer_far_side (.hclk(hclk), .hresetn(hresetn), .message(message),
        .message_valid(message_valid), .sync_err(sync_err), .fin_delay(fin_delay),
        .slave_ready_line(sr_line), .status_n(status_n), .finished_n(fin_n));
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    // Logged mid-cycle so the registered message has settled
    always @(negedge hclk) if (message_valid === 1'b1) mq.push_back(message);
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task give_verdict;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wait_ready;
        int n;
        n = 0;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 40);
        if (n >= 40) begin err_total++; give_verdict(); end
    endtask
    // Single word transfer; read data taken at the data phase's ready edge
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_ready();
        r = hrdata;
    endtask
    task chk_msg(input logic [11:0] exp, input logic [11:0] m);
        int n;
        n = 0;
        while (mq.size() == 0 && n < 40) begin @(posedge hclk); n++; end
        if (n >= 40) begin err_total++; give_verdict(); end
        chk("message", {20'h0, exp & m}, {20'h0, mq.pop_front() & m});
    endtask
    task pulse(input logic first, input logic [23:0] x);
        xing <= x;
        fla <= first;
        sla <= !first;
        @(posedge hclk);
        fla <= 1'b0;
        sla <= 1'b0;
    endtask
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        {hsel, hwrite, fla, sla, sync_err, haddr, hwdata, htrans, xing} = '0;
        hsize = 3'h2;
        fin_delay = 4'h1;
        hresetn = 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1'b0, msg_ctrl_pkg::A_CTRL, 32'h0);
        chk("ctrl reset", msg_ctrl_pkg::CTRL_RESET, r);
        xfer(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h0, r);
        for (int i = 0; i < 2; i++) begin
            pulse(1'b1, 24'h5a3c80 + 24'(i));
            chk_msg({4'h1, 8'(i)}, 12'hfff);
            chk_msg({4'h3, 8'h80 + 8'(i)}, 12'hfff);
        end
        for (int i = 0; i < 2; i++) begin
            fin_delay <= (i == 0) ? 4'h1 : 4'hc;
            pulse(1'b0, 24'h0);
            chk_msg({4'h4, 8'(i)}, 12'hfff);
            chk("slave ready idle", 32'h1, {31'h0, sr_line});
            chk_msg({4'h5, 8'(i)}, 12'hfff);
            k = 0;
            do begin xfer(1'b0, msg_ctrl_pkg::A_COUNT, 32'h0); k++; end
                while (r !== 32'(i + 1) && k < 40);
            chk("count", 32'(i + 1), r);
        end
        for (int i = 0; i < 3; i++) begin
            xfer(1'b1, msg_ctrl_pkg::A_CTRL, cw[i]);
            chk_msg(ce[i], cm[i]);
        end
        xfer(1'b0, msg_ctrl_pkg::A_CTRL, 32'h0);
        chk("ctrl self clear", msg_ctrl_pkg::CTRL_RESET, r);
        sync_err <= 1'b1;
        repeat (4) @(posedge hclk);
        xfer(1'b0, msg_ctrl_pkg::A_STATUS, 32'h0);
        chk("status set", 32'hc, r & 32'h3ff);
        sync_err <= 1'b0;
        repeat (4) @(posedge hclk);
        xfer(1'b0, msg_ctrl_pkg::A_STATUS, 32'h0);
        chk("status hold", 32'h8, r & 32'h3ff);
        pulse(1'b1, 24'h000011);
        chk_msg(12'h102, 12'hfff);
        chk_msg(12'h311, 12'hfff);
        repeat (12) @(posedge hclk);
        xfer(1'b0, msg_ctrl_pkg::A_STATUS, 32'h0);
        chk("status clear", 32'h0, r & 32'h3ff);
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge hclk);
        err_total++;
        give_verdict();
    end
endmodule
`default_nettype wire
